// ---- common/core_trap_regs.vh ----
// Register offsets, field positions and reset values for core control and trap status
`ifndef CORE_TRAP_REGS_VH
`define CORE_TRAP_REGS_VH

// ============================================================
// Register offsets (byte addresses on the APB)
`define CORE_CONTROL_OFFSET 12'h000
`define TRAP_CONTROL_OFFSET 12'h004

// ============================================================
// Core control fields
`define CC_VAR_BIT 15
`define CC_US_HI 13
`define CC_US_LO 12
`define CC_EDT_BIT 11
`define CC_DL_HI 10
`define CC_DL_LO 8
`define CC_ACC_A_SAT_EN_BIT 7
`define CC_ACC_B_SAT_EN_BIT 6
`define CC_DSP_WRITE_SAT_EN_BIT 5
`define CC_SUPER_SAT_SEL_BIT 4
`define CC_PRIORITY_MSB_BIT 3
`define CC_RND_BIT 1
`define CC_RESET 16'h0020

// Multiply sign mode codes
`define US_SIGNED 2'h0
`define US_UNSIGNED 2'h1
`define US_MIXED 2'h2
`define US_RESERVED 2'h3

// ============================================================
// Trap and nesting control fields
`define TC_NESTING_DISABLE_BIT 15
`define TC_ACC_A_OVERFLOW_TRAP_EN_BIT 10
`define TC_ACC_B_OVERFLOW_TRAP_EN_BIT 9
`define TC_CATASTROPHIC_TRAP_EN_BIT 8
`define TC_RESET 16'h0000

// Sticky flag bank: index order inside the bank
`define FLAG_COUNT 11
`define FL_OVA 10
`define FL_OVB 9
`define FL_COVA 8
`define FL_COVB 7
`define FL_SHIFT 6
`define FL_DIV0 5
`define FL_DMA 4
`define FL_MATH 3
`define FL_ADDR 2
`define FL_STACK 1
`define FL_OSC 0

// Loop nesting depth
`define DEPTH_WIDTH 3
`define DEPTH_MAX 3'h7

`endif

// ---- verilog/trap_flag_bank.v ----
// Sticky trap cause flags, set by hardware, written by software
`timescale 1ns/10ps
`default_nettype none
`include "core_trap_regs.vh"

module trap_flag_bank (
    input wire ref_clk, // Core clock
    input wire reset_n, // Synchronous reset, active low
    input wire [`FLAG_COUNT-1:0] set_pulse, // Hardware set, one per flag
    input wire write_en, // Software write strobe
    input wire [`FLAG_COUNT-1:0] write_data, // Software write value
    output wire [`FLAG_COUNT-1:0] flags // Current flag state
);

    reg [`FLAG_COUNT-1:0] flag_reg;

    assign flags = flag_reg;

    // ============================================================
    // Per-flag storage
    genvar i;
    generate
        for (i = 0; i < `FLAG_COUNT; i = i + 1) begin : g_flag
            // Set beats a same-cycle software clear so no trap cause is lost
            always @(posedge ref_clk) begin
                if (!reset_n) begin
                    flag_reg[i] <= 1'b0;
                end else if (set_pulse[i]) begin
                    flag_reg[i] <= 1'b1; // [RULE19]
                end else if (write_en) begin
                    flag_reg[i] <= write_data[i]; // [RULE19]
                end
            end
        end
    endgenerate

endmodule // trap_flag_bank
`default_nettype wire

// ---- verilog/loop_depth_counter.v ----
// Count of active nested hardware loops, saturating at both ends
`timescale 1ns/10ps
`default_nettype none
`include "core_trap_regs.vh"

module loop_depth_counter (
    input wire ref_clk, // Core clock
    input wire reset_n, // Synchronous reset, active low
    input wire loop_enter, // Pipeline starts a loop
    input wire loop_exit, // Pipeline finishes a loop
    output wire [`DEPTH_WIDTH-1:0] depth // Active loop count
);

    reg [`DEPTH_WIDTH-1:0] depth_reg;
    reg [`DEPTH_WIDTH-1:0] depth_next;

    assign depth = depth_reg;

    // ============================================================
    // Depth tracking
    // Enter and exit together leave the count unchanged
    always @* begin
        depth_next = depth_reg;
        if (loop_enter && !loop_exit && depth_reg != `DEPTH_MAX) begin
            depth_next = depth_reg + 3'h1; // [RULE5]
        end else if (loop_exit && !loop_enter && depth_reg != 3'h0) begin
            depth_next = depth_reg - 3'h1; // [RULE5]
        end
    end

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            depth_reg <= 3'h0;
        end else begin
            depth_reg <= depth_next;
        end
    end

endmodule // loop_depth_counter
`default_nettype wire

// ---- verilog/core_dsp_control_and_trap_status.v ----
// Core control and trap status registers with APB access
//
// How it works
// [RULE1] Control bit 15 set selects variable exception latency, clear selects fixed.
// [RULE2] Sign field: 00 signed, 01 unsigned, 10 mixed, 11 reserved.
// [RULE3] Writing 1 to early loop end stops the loop after this iteration.
// [RULE4] The early loop end bit always reads as zero.
// [RULE5] Read-only three-bit field gives count of active nested loops, 0 to 7.
// [RULE6] Separate saturation enables for accumulator A and accumulator B.
// [RULE7] Data write saturation enable resets to 1; other writable control bits to 0.
// [RULE8] Saturation mode bit: 1 selects 9.31, 0 selects 1.31.
// [RULE9] Priority bit 3 is the top bit above status bits 7 to 5.
// [RULE10] Nesting disable stops an interrupt preempting a handler in service.
// [RULE11] Ordinary overflow trap of each accumulator sets its own flag.
// [RULE12] Catastrophic overflow trap of each accumulator sets its own flag.
// [RULE13] Per-accumulator enables gate ordinary overflow traps.
// [RULE14] One enable gates catastrophic overflow traps of both accumulators.
// [RULE15] Invalid accumulator shift math trap sets its status bit.
// [RULE16] Divide by zero math trap sets its status bit.
// [RULE17] DMA controller trap sets its flag.
// [RULE18] Unimplemented bits read zero and ignore writes.
// [RULE19] Trap flags stay set until software writes zero.
// [RULE20] Math, address, stack and oscillator flags set on their trap conditions.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "core_trap_regs.vh"

module core_dsp_control_and_trap_status (
    input wire ref_clk, // Core clock, 250 MHz
    input wire reset_n, // Synchronous reset, active low
    // APB slave
    input wire psel, // Slave select
    input wire penable, // Access phase
    input wire pwrite, // Write when high
    input wire [11:0] paddr, // Byte address
    input wire [31:0] pwdata, // Write data
    output reg [31:0] prdata, // Read data
    output reg pready, // Transfer complete
    output reg pslverr, // Unmapped address
    // Pipeline and DSP engine events
    input wire loop_enter, // Hardware loop starts
    input wire loop_exit, // Hardware loop ends
    input wire acc_a_overflow, // Accumulator A ordinary overflow
    input wire acc_b_overflow, // Accumulator B ordinary overflow
    input wire acc_a_catastrophic, // Accumulator A catastrophic overflow
    input wire acc_b_catastrophic, // Accumulator B catastrophic overflow
    input wire bad_shift, // Invalid accumulator shift
    input wire zero_divide, // Divide by zero attempted
    input wire dma_trap, // DMA controller trap
    input wire address_error, // Address error trap
    input wire stack_error, // Stack error trap
    input wire osc_failure, // Oscillator failure trap
    // Exception sequencer
    input wire [2:0] priority_low_bits, // Priority bits from status word 7:5
    input wire priority_msb_in, // Sequencer priority above 7
    input wire irq_preempt_req, // Pending interrupt wants to preempt
    input wire handler_in_service, // A handler is running
    // Control outputs
    output reg variable_latency, // Variable exception latency
    output reg [1:0] multiply_sign_mode, // Stored sign field
    output reg mul_signed, // Signed multiplies
    output reg mul_unsigned, // Unsigned multiplies
    output reg mul_mixed, // Mixed-sign multiplies
    output reg early_loop_end, // End current loop, one-cycle pulse
    output reg [2:0] loop_nest_depth, // Active loop count
    output reg acc_a_sat_en, // Accumulator A saturation
    output reg acc_b_sat_en, // Accumulator B saturation
    output reg dsp_write_sat_en, // Data write saturation
    output reg super_sat_sel, // 9.31 saturation when high
    output reg rounding_mode, // Rounding select
    output reg [3:0] cpu_priority_level, // Full priority level
    output reg priority_msb_clear, // Software cleared top priority bit, pulse
    output reg nesting_disable, // Interrupt nesting disabled
    output reg preempt_grant, // Preemption allowed
    output reg math_trap_req, // Math error trap raised, pulse
    output reg address_trap_req, // Address error trap raised, pulse
    output reg stack_trap_req, // Stack error trap raised, pulse
    output reg osc_trap_req, // Oscillator failure trap raised, pulse
    output reg dma_trap_req // DMA trap raised, pulse
);

    // ============================================================
    // Declarations
    reg var_reg;
    reg [1:0] us_reg;
    reg acc_a_sat_en_reg;
    reg acc_b_sat_en_reg;
    reg dsp_write_sat_en_reg;
    reg super_sat_sel_reg;
    reg rnd_reg;
    reg nesting_disable_reg;
    reg acc_a_overflow_trap_en_reg;
    reg acc_b_overflow_trap_en_reg;
    reg catastrophic_trap_en_reg;
    reg [15:0] core_rd;
    reg [15:0] trap_rd;
    reg [31:0] rd_next;
    reg hit_core;
    reg hit_trap;
    wire setup_phase;
    wire access_done;
    wire wr_core;
    wire wr_trap;
    wire ova_set;
    wire ovb_set;
    wire cova_set;
    wire covb_set;
    wire math_set;
    wire [`FLAG_COUNT-1:0] flag_set;
    wire [`FLAG_COUNT-1:0] flag_wdata;
    wire [`FLAG_COUNT-1:0] flags;
    wire [2:0] depth;

    // ============================================================
    // APB decode
    assign setup_phase = psel && !penable;
    // Write takes effect only on the access edge that also sees pready
    assign access_done = psel && penable && pready;
    assign wr_core = access_done && pwrite && hit_core;
    assign wr_trap = access_done && pwrite && hit_trap;

    always @* begin
        hit_core = (paddr == `CORE_CONTROL_OFFSET);
        hit_trap = (paddr == `TRAP_CONTROL_OFFSET);
    end

    // ============================================================
    // Read views
    always @* begin
        core_rd = 16'h0000; // [RULE18]
        core_rd[`CC_VAR_BIT] = var_reg;
        core_rd[`CC_US_HI:`CC_US_LO] = us_reg;
        core_rd[`CC_EDT_BIT] = 1'b0; // [RULE4]
        core_rd[`CC_DL_HI:`CC_DL_LO] = depth; // [RULE5]
        core_rd[`CC_ACC_A_SAT_EN_BIT] = acc_a_sat_en_reg;
        core_rd[`CC_ACC_B_SAT_EN_BIT] = acc_b_sat_en_reg;
        core_rd[`CC_DSP_WRITE_SAT_EN_BIT] = dsp_write_sat_en_reg;
        core_rd[`CC_SUPER_SAT_SEL_BIT] = super_sat_sel_reg;
        core_rd[`CC_PRIORITY_MSB_BIT] = priority_msb_in; // [RULE9]
        core_rd[`CC_RND_BIT] = rnd_reg;
    end

    always @* begin
        trap_rd = 16'h0000; // [RULE18]
        trap_rd[`TC_NESTING_DISABLE_BIT] = nesting_disable_reg;
        trap_rd[14] = flags[`FL_OVA];
        trap_rd[13] = flags[`FL_OVB];
        trap_rd[12] = flags[`FL_COVA];
        trap_rd[11] = flags[`FL_COVB];
        trap_rd[`TC_ACC_A_OVERFLOW_TRAP_EN_BIT] = acc_a_overflow_trap_en_reg;
        trap_rd[`TC_ACC_B_OVERFLOW_TRAP_EN_BIT] = acc_b_overflow_trap_en_reg;
        trap_rd[`TC_CATASTROPHIC_TRAP_EN_BIT] = catastrophic_trap_en_reg;
        trap_rd[7:1] = flags[`FL_SHIFT:`FL_OSC];
    end

    always @* begin
        rd_next = 32'h0000_0000;
        if (hit_core) begin
            rd_next = {16'h0000, core_rd};
        end else if (hit_trap) begin
            rd_next = {16'h0000, trap_rd};
        end
    end

    // Read data is latched in the setup cycle; one wait-free access phase
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            if (setup_phase) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_next;
                pslverr <= !(hit_core || hit_trap);
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ============================================================
    // Core control register
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            var_reg <= 1'b0;
            us_reg <= `US_SIGNED;
            acc_a_sat_en_reg <= 1'b0;
            acc_b_sat_en_reg <= 1'b0;
            dsp_write_sat_en_reg <= 1'b1; // [RULE7]
            super_sat_sel_reg <= 1'b0;
            rnd_reg <= 1'b0;
        end else if (wr_core) begin
            var_reg <= pwdata[`CC_VAR_BIT]; // [RULE1]
            // Reserved sign code is refused so the engine never sees it
            if (pwdata[`CC_US_HI:`CC_US_LO] != `US_RESERVED) begin
                us_reg <= pwdata[`CC_US_HI:`CC_US_LO]; // [RULE2]
            end
            acc_a_sat_en_reg <= pwdata[`CC_ACC_A_SAT_EN_BIT]; // [RULE6]
            acc_b_sat_en_reg <= pwdata[`CC_ACC_B_SAT_EN_BIT]; // [RULE6]
            dsp_write_sat_en_reg <= pwdata[`CC_DSP_WRITE_SAT_EN_BIT]; // [RULE7]
            super_sat_sel_reg <= pwdata[`CC_SUPER_SAT_SEL_BIT]; // [RULE8]
            rnd_reg <= pwdata[`CC_RND_BIT];
        end
    end

    // ============================================================
    // Trap and nesting control register
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            nesting_disable_reg <= 1'b0;
            acc_a_overflow_trap_en_reg <= 1'b0;
            acc_b_overflow_trap_en_reg <= 1'b0;
            catastrophic_trap_en_reg <= 1'b0;
        end else if (wr_trap) begin
            nesting_disable_reg <= pwdata[`TC_NESTING_DISABLE_BIT]; // [RULE10]
            acc_a_overflow_trap_en_reg <= pwdata[`TC_ACC_A_OVERFLOW_TRAP_EN_BIT]; // [RULE13]
            acc_b_overflow_trap_en_reg <= pwdata[`TC_ACC_B_OVERFLOW_TRAP_EN_BIT]; // [RULE13]
            catastrophic_trap_en_reg <= pwdata[`TC_CATASTROPHIC_TRAP_EN_BIT]; // [RULE14]
        end
    end

    // ============================================================
    // Trap qualification
    // Overflow only counts as a trap cause when its enable is set
    assign ova_set = acc_a_overflow && acc_a_overflow_trap_en_reg; // [RULE11] [RULE13]
    assign ovb_set = acc_b_overflow && acc_b_overflow_trap_en_reg; // [RULE11] [RULE13]
    assign cova_set = acc_a_catastrophic && catastrophic_trap_en_reg; // [RULE12] [RULE14]
    assign covb_set = acc_b_catastrophic && catastrophic_trap_en_reg; // [RULE12] [RULE14]
    assign math_set = ova_set || ovb_set || cova_set || covb_set || bad_shift || zero_divide; // [RULE20]

    assign flag_set[`FL_OVA] = ova_set;
    assign flag_set[`FL_OVB] = ovb_set;
    assign flag_set[`FL_COVA] = cova_set;
    assign flag_set[`FL_COVB] = covb_set;
    assign flag_set[`FL_SHIFT] = bad_shift; // [RULE15]
    assign flag_set[`FL_DIV0] = zero_divide; // [RULE16]
    assign flag_set[`FL_DMA] = dma_trap; // [RULE17]
    assign flag_set[`FL_MATH] = math_set; // [RULE20]
    assign flag_set[`FL_ADDR] = address_error; // [RULE20]
    assign flag_set[`FL_STACK] = stack_error; // [RULE20]
    assign flag_set[`FL_OSC] = osc_failure; // [RULE20]

    assign flag_wdata = {pwdata[14:11], pwdata[7:1]};

    trap_flag_bank u_flags (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .set_pulse(flag_set),
        .write_en(wr_trap),
        .write_data(flag_wdata),
        .flags(flags)
    );

    loop_depth_counter u_depth (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .loop_enter(loop_enter),
        .loop_exit(loop_exit),
        .depth(depth)
    );

    // ============================================================
    // Registered outputs
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            variable_latency <= 1'b0;
            multiply_sign_mode <= `US_SIGNED;
            mul_signed <= 1'b1;
            mul_unsigned <= 1'b0;
            mul_mixed <= 1'b0;
            early_loop_end <= 1'b0;
            loop_nest_depth <= 3'h0;
            acc_a_sat_en <= 1'b0;
            acc_b_sat_en <= 1'b0;
            dsp_write_sat_en <= 1'b1;
            super_sat_sel <= 1'b0;
            rounding_mode <= 1'b0;
            cpu_priority_level <= 4'h0;
            priority_msb_clear <= 1'b0;
            nesting_disable <= 1'b0;
            preempt_grant <= 1'b0;
            math_trap_req <= 1'b0;
            address_trap_req <= 1'b0;
            stack_trap_req <= 1'b0;
            osc_trap_req <= 1'b0;
            dma_trap_req <= 1'b0;
        end else begin
            variable_latency <= var_reg; // [RULE1]
            multiply_sign_mode <= us_reg;
            mul_signed <= (us_reg == `US_SIGNED); // [RULE2]
            mul_unsigned <= (us_reg == `US_UNSIGNED); // [RULE2]
            mul_mixed <= (us_reg == `US_MIXED); // [RULE2]
            early_loop_end <= wr_core && pwdata[`CC_EDT_BIT]; // [RULE3]
            loop_nest_depth <= depth; // [RULE5]
            acc_a_sat_en <= acc_a_sat_en_reg; // [RULE6]
            acc_b_sat_en <= acc_b_sat_en_reg; // [RULE6]
            dsp_write_sat_en <= dsp_write_sat_en_reg; // [RULE7]
            super_sat_sel <= super_sat_sel_reg; // [RULE8]
            rounding_mode <= rnd_reg;
            cpu_priority_level <= {priority_msb_in, priority_low_bits}; // [RULE9]
            // Bit is clearable only: a written 0 asks the sequencer to drop it
            priority_msb_clear <= wr_core && !pwdata[`CC_PRIORITY_MSB_BIT] && priority_msb_in;
            nesting_disable <= nesting_disable_reg; // [RULE10]
            preempt_grant <= irq_preempt_req && !(nesting_disable_reg && handler_in_service); // [RULE10]
            math_trap_req <= math_set; // [RULE13] [RULE14]
            address_trap_req <= address_error;
            stack_trap_req <= stack_error;
            osc_trap_req <= osc_failure;
            dma_trap_req <= dma_trap;
        end
    end

endmodule // core_dsp_control_and_trap_status
`default_nettype wire

// ---- testbench/pipe_event_model.sv ----
// Behavioural pipeline, DSP engine and trap source facing the block
`timescale 1ns/10ps
`default_nettype none
module pipe_event_model (
    input wire logic ref_clk, // Core clock
    input wire logic fire, // Issue the pattern this cycle
    input wire logic [11:0] ev, // Loop and trap pattern
    output logic [11:0] ev_q // Registered event pulses
);
    // ============================================================
    // Events
    // One-cycle pulses only: a held level would set flags repeatedly
    always @(posedge ref_clk) begin
        ev_q <= fire ? ev : 12'h000;
    end
endmodule // pipe_event_model
`default_nettype wire

// ---- testbench/core_trap_props.sv ----
// Port checker for core control and trap status
`timescale 1ns/10ps
`default_nettype none
module core_trap_props (
    input wire logic ref_clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic psel, // Bus
    input wire logic penable, // Bus
    input wire logic pwrite, // Bus
    input wire logic [11:0] paddr, // Bus
    input wire logic [31:0] pwdata, // Bus
    input wire logic [31:0] prdata, // Bus
    input wire logic pready, // Bus
    input wire logic bad_shift, // Trap in
    input wire logic zero_divide, // Trap in
    input wire logic dma_trap, // Trap in
    input wire logic [2:0] priority_low_bits, // Priority
    input wire logic priority_msb_in, // Priority
    input wire logic irq_preempt_req, // Preempt
    input wire logic handler_in_service, // Preempt
    input wire logic variable_latency, // Control
    input wire logic [1:0] multiply_sign_mode, // Control
    input wire logic mul_signed, // Control
    input wire logic mul_unsigned, // Control
    input wire logic mul_mixed, // Control
    input wire logic early_loop_end, // Control
    input wire logic [2:0] loop_nest_depth, // Status
    input wire logic acc_a_sat_en, // Control
    input wire logic acc_b_sat_en, // Control
    input wire logic dsp_write_sat_en, // Control
    input wire logic super_sat_sel, // Control
    input wire logic [3:0] cpu_priority_level, // Status
    input wire logic nesting_disable, // Control
    input wire logic preempt_grant, // Status
    input wire logic math_trap_req, // Trap out
    input wire logic dma_trap_req // Trap out
);
    // ============================================================
    // Completed transfers
    wire acc = psel && penable && pready;
    wire wr_ctl = acc && pwrite && paddr == 12'h000;
    wire wr_trp = acc && pwrite && paddr == 12'h004;
    wire rd_ctl = acc && !pwrite && paddr == 12'h000;
    wire edt_wr = wr_ctl && pwdata[11];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    property p_copy(hit, src, dst);
        logic v;
        (hit, v = src) |=> ##1 dst == v;
    endproperty
    property p_sat;
        logic [3:0] v;
        (wr_ctl, v = pwdata[7:4]) |=> ##1 {acc_a_sat_en, acc_b_sat_en, dsp_write_sat_en, super_sat_sel} == v;
    endproperty
    a_one_wait: assert property (s_setup |=> s_access) else $error("ready missing in access cycle");
    a_var_latency: assert property (p_copy(wr_ctl, pwdata[15], variable_latency))
        else $error("latency mode not written");
    a_sign_decode: assert property (multiply_sign_mode != 2'h3 &&
        {mul_signed, mul_unsigned, mul_mixed} == (3'h4 >> multiply_sign_mode)) else $error("sign decode wrong");
    a_sign_keep: assert property (wr_ctl && pwdata[13:12] == 2'h3 |=> ##1 $stable(multiply_sign_mode))
        else $error("reserved sign code stored");
    a_early_pulse: assert property (early_loop_end == $past(edt_wr))
        else $error("loop end pulse wrong");
    a_edt_zero: assert property (rd_ctl |-> prdata[31:16] == 16'h0000 && !prdata[14] && !prdata[11])
        else $error("unimplemented or loop end bit reads one");
    a_depth_read: assert property (rd_ctl |-> prdata[10:8] == loop_nest_depth)
        else $error("depth field differs");
    a_sat_write: assert property (p_sat)
        else $error("saturation controls not written");
    a_prio_level: assert property ($past(reset_n) |->
        cpu_priority_level == {$past(priority_msb_in), $past(priority_low_bits)}) else $error("priority wrong");
    a_nest_write: assert property (p_copy(wr_trp, pwdata[15], nesting_disable))
        else $error("nesting disable not written");
    // Grant and the mirrored disable are both registered from the same register on the same edge
    a_nest_block: assert property (nesting_disable && $past(handler_in_service)
        |-> !preempt_grant) else $error("preempt while nesting disabled");
    a_math_pulse: assert property (bad_shift || zero_divide |=> math_trap_req)
        else $error("math trap missing");
    a_dma_pulse: assert property ($past(reset_n) |-> dma_trap_req == $past(dma_trap))
        else $error("dma trap pulse wrong");
endmodule // core_trap_props
bind core_dsp_control_and_trap_status core_trap_props chk (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for core control and trap status
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic ref_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000, ev = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, seed = 32'h0000_2ec7;
    logic [2:0] pri_lo = 3'h0;
    logic pri_hi = 1'h0, irq = 1'h0, hdl = 1'h0, fire = 1'h0;
    logic [32:0] notes[$];
    int n_mismatch = 0, tests_run = 0;
    wire [11:0] ev_q;
    wire [31:0] prdata;
    wire pready, pslverr, mul_s, mul_u, mul_m;
    always #2 ref_clk = ~ref_clk;
    pipe_event_model events (.ref_clk(ref_clk), .fire(fire), .ev(ev), .ev_q(ev_q));
    core_dsp_control_and_trap_status DUT (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .loop_enter(ev_q[11]), .loop_exit(ev_q[10]), .acc_a_overflow(ev_q[9]), .acc_b_overflow(ev_q[8]),
        .acc_a_catastrophic(ev_q[7]), .acc_b_catastrophic(ev_q[6]), .bad_shift(ev_q[5]),
        .zero_divide(ev_q[4]), .dma_trap(ev_q[3]), .address_error(ev_q[2]), .stack_error(ev_q[1]),
        .osc_failure(ev_q[0]), .priority_low_bits(pri_lo), .priority_msb_in(pri_hi), .irq_preempt_req(irq),
        .handler_in_service(hdl), .variable_latency(), .multiply_sign_mode(), .mul_signed(mul_s),
        .mul_unsigned(mul_u), .mul_mixed(mul_m), .early_loop_end(), .loop_nest_depth(), .acc_a_sat_en(),
        .acc_b_sat_en(), .dsp_write_sat_en(), .super_sat_sel(), .rounding_mode(), .cpu_priority_level(),
        .priority_msb_clear(), .nesting_disable(), .preempt_grant(), .math_trap_req(),
        .address_trap_req(), .stack_trap_req(), .osc_trap_req(), .dma_trap_req());
    // ============================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk_read(input logic [32:0] exp);
        tests_run++;
        if ({pslverr, prdata} !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t read %h expected %h", $time, {pslverr, prdata}, exp);
        end
    endtask
    task automatic chk_level(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t level %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Reads leave their expectation for the monitor; writes expect nothing
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        int n = 0;
        if (!w) notes.push_back(e);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1) begin
            n_mismatch++;
            complete_run();
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge ref_clk);
    endtask
    task automatic pulse(input logic [11:0] p);
        logic [31:0] r;
        r = rnd();
        fire <= 1'h1;
        ev <= p;
        irq <= r[0];
        hdl <= r[1];
        pri_lo <= r[4:2];
        @(posedge ref_clk);
        fire <= 1'h0;
        repeat (2) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'h1 && !pwrite) chk_read(notes.pop_front());
    end
    // ============================================================
    // Scenarios
    initial begin
        logic [31:0] r;
        logic [15:0] w, ew, ctl, et;
        logic m;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'h1;
        apb(1'h0, 12'h000, 32'h0000_0000, 33'h0_0000_0020);
        apb(1'h0, 12'h004, 32'h0000_0000, 33'h0_0000_0000);
        apb(1'h0, 12'h008, 32'h0000_0000, 33'h1_0000_0000);
        pri_hi <= 1'h1;
        for (int c = 0; c < 4; c++) begin
            r = rnd();
            w = {~c[0], 1'h1, c[1:0], 1'h1, 3'h7, r[7:4], 1'h0, 1'h1, r[1], 1'h1};
            ew = w & 16'hb0f2;
            if (c == 3) ew[13:12] = 2'h2;
            ew[3] = 1'h1;
            apb(1'h1, 12'h000, {16'h0000, w}, 33'h0_0000_0000);
            // Decoded mode lands one edge after the register
            @(posedge ref_clk);
            chk_level({mul_s, mul_u, mul_m}, 3'h4 >> ew[13:12]);
            apb(1'h0, 12'h000, 32'h0000_0000, {17'h0_0000, ew});
        end
        apb(1'h1, 12'h00c, 32'hffff_ffff, 33'h0_0000_0000);
        repeat (8) pulse(12'h800);
        apb(1'h0, 12'h000, 32'h0000_0000, {17'h0_0000, ew | 16'h0700});
        repeat (8) pulse(12'h400);
        apb(1'h0, 12'h000, 32'h0000_0000, {17'h0_0000, ew});
        for (int i = 0; i < 10; i++) begin
            r = rnd();
            ctl = {r[13], 4'h0, r[2:0], 8'h00};
            m = (r[12] & r[2]) | (r[11] & r[1]) | ((r[10] | r[9]) & r[0]) | r[8] | r[7];
            et = ctl | {1'h0, r[12] & r[2], r[11] & r[1], r[10] & r[0], r[9] & r[0], 3'h0, r[8:6], m, r[5:3], 1'h0};
            apb(1'h1, 12'h004, {16'h0000, ctl}, 33'h0_0000_0000);
            pulse({2'h0, r[12:3]});
            apb(1'h0, 12'h004, 32'h0000_0000, {17'h0_0000, et});
            apb(1'h0, 12'h004, 32'h0000_0000, {17'h0_0000, et});
            apb(1'h1, 12'h004, {16'h0000, ctl}, 33'h0_0000_0000);
            apb(1'h0, 12'h004, 32'h0000_0000, {17'h0_0000, ctl});
        end
        complete_run();
    end
endmodule // testbench
`default_nettype wire
